// >>> rtl/smf_top.sv
// Purpose: Frames multi-speed and all-speeds ASCII messages for a serial link
// Assumes: A UART on the same clock takes bytes by valid/ready and flags idle
// Notes: Speeds are BCD nibbles written by software, blank nibble above nine
//
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
module smf_top (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_idle,
	output logic busy
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [31:0] period;
		logic [4:0][19:0] spd;
		logic [15:0] sctl;
		logic [4:0][19:0] sspd;
		smf_pkg::smf_st_t st;
		logic [3:0] idx;
		logic [1:0] kind;
		logic [31:0] cnt;
		logic pend;
		logic busy;
		logic [15:0] msgs;
		logic [31:0] rdata;
	} smf_top_t;

	smf_top_t s_r;
	smf_top_t s_nxt;
	smf_byte_if bif ();

	logic [7:0] blk_byte;
	logic blk_alt;
	logic [19:0] blk_prim;
	logic [19:0] blk_sec;
	logic [7:0] blk_stat;
	logic [7:0] hdr_byte;
	logic [7:0] cfg_b;
	logic [7:0] st_b;
	logic [7:0] cfg_e;
	logic [7:0] st_e;
	logic [7:0] cnt_e;
	logic [3:0] hdr_len;
	logic last_blk;
	logic start;
	logic adv;

	// Next enabled block after the given one, K_NONE when done
	function automatic logic [1:0] next_kind(input logic [1:0] k, input logic pk, input logic ht);
		next_kind = smf_pkg::K_NONE;
		if (k == smf_pkg::K_LIVE && pk) begin
			next_kind = smf_pkg::K_PEAK;
		end else if (k != smf_pkg::K_HIT && ht) begin
			next_kind = smf_pkg::K_HIT;
		end
	endfunction : next_kind

	// Three digits of a multi-speed field; tenths mode drops hundreds
	function automatic logic [7:0] pick3(input logic [19:0] v, input logic tenths, input logic [3:0] j);
		pick3 = smf_pkg::smf_asc(smf_pkg::smf_nib(v, 3'(tenths ? (4'd2 - j) : (4'd3 - j))));
	endfunction : pick3

	always_comb begin
		cfg_b = {smf_pkg::B_ASCII_TOP, s_r.sctl[smf_pkg::C_LOCK], s_r.sctl[smf_pkg::C_OUTB],
			s_r.sctl[smf_pkg::C_FORK], 1'b0, 1'b1, s_r.sctl[smf_pkg::C_XMIT]};
		st_b = {smf_pkg::B_ASCII_TOP, 3'b000, s_r.sctl[smf_pkg::C_PEAK], 2'b00};
		cfg_e = {smf_pkg::B_ASCII_TOP, 1'b0, s_r.sctl[smf_pkg::C_TENTHS], 2'b00,
			s_r.sctl[smf_pkg::C_PEAK], s_r.sctl[smf_pkg::C_FORK]};
		st_e = {smf_pkg::B_ASCII_TOP, smf_pkg::B_ALL_STATUS_LOW};
		cnt_e = smf_pkg::B_CNT_ONE + {7'h00, s_r.sctl[smf_pkg::C_PEAK]} + {7'h00, s_r.sctl[smf_pkg::C_HIT]};
		hdr_len = s_r.sctl[smf_pkg::C_FMT] ? smf_pkg::LEN_HDR_ALL : smf_pkg::LEN_HDR_MULTI;
		hdr_byte = smf_pkg::B_ZERO;
		if (s_r.sctl[smf_pkg::C_FMT]) begin
			case (s_r.idx)
				4'd0: hdr_byte = smf_pkg::B_TYPE_ALL;
				4'd1: hdr_byte = cfg_e;
				4'd2: hdr_byte = st_e;
				4'd6: hdr_byte = cnt_e;
				default: hdr_byte = smf_pkg::B_ZERO;
			endcase
		end else begin
			case (s_r.idx)
				4'd0: hdr_byte = smf_pkg::B_TYPE_MULTI;
				4'd1: hdr_byte = cfg_b;
				4'd2: hdr_byte = st_b;
				4'd6, 4'd7, 4'd8: hdr_byte = pick3(s_r.sspd[smf_pkg::SPD_LOCKED], s_r.sctl[smf_pkg::C_TENTHS],
					s_r.idx - 4'd6);
				4'd9, 4'd10, 4'd11: hdr_byte = pick3(s_r.sspd[smf_pkg::SPD_PEAK], s_r.sctl[smf_pkg::C_TENTHS],
					s_r.idx - 4'd9);
				4'd12, 4'd13, 4'd14: hdr_byte = pick3(s_r.sspd[smf_pkg::SPD_LIVE], s_r.sctl[smf_pkg::C_TENTHS],
					s_r.idx - 4'd12);
				default: hdr_byte = smf_pkg::B_ZERO;
			endcase
		end
	end

	// Speed pair and status for the block being sent
	always_comb begin
		case (s_r.kind)
			smf_pkg::K_LIVE: begin
				blk_prim = s_r.sspd[smf_pkg::SPD_LIVE];
				blk_sec = s_r.sspd[smf_pkg::SPD_LOCKED];
			end
			smf_pkg::K_PEAK: begin
				blk_prim = s_r.sspd[smf_pkg::SPD_PEAK];
				blk_sec = s_r.sspd[smf_pkg::SPD_HIPEAK];
			end
			default: begin
				blk_prim = s_r.sspd[smf_pkg::SPD_HIT];
				blk_sec = smf_pkg::SPD_RST;
			end
		endcase
		blk_stat = {smf_pkg::B_ASCII_TOP, 3'b000, s_r.sctl[smf_pkg::C_DIR + 2*s_r.kind + 1],
			s_r.sctl[smf_pkg::C_DIR + 2*s_r.kind], s_r.sctl[smf_pkg::C_XMIT]};
	end

	smf_block u_block (
		.kind(s_r.kind),
		.idx(s_r.idx),
		.prim(blk_prim),
		.sec(blk_sec),
		.stat(blk_stat),
		.byte_o(blk_byte),
		.alt(blk_alt)
	);

	always_comb begin
		bif.valid = (s_r.st == smf_pkg::SMF_HDR) || (s_r.st == smf_pkg::SMF_BLK) || (s_r.st == smf_pkg::SMF_CR);
		case (s_r.st)
			smf_pkg::SMF_HDR: bif.data = hdr_byte;
			smf_pkg::SMF_BLK: bif.data = blk_byte;
			default: bif.data = smf_pkg::B_CR;
		endcase
	end

	smf_buf u_buf (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_if(bif),
		.out_data(tx_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready)
	);

	always_comb begin
		s_nxt = s_r;
		adv = bif.valid && bif.ready;
		last_blk = next_kind(s_r.kind, s_r.sctl[smf_pkg::C_PEAK], s_r.sctl[smf_pkg::C_HIT]) == smf_pkg::K_NONE;
		// Period runs down and parks at zero until the framer is free
		if (s_r.cnt != 32'h0) begin
			s_nxt.cnt = s_r.cnt - 32'h1;
		end
		start = (s_r.st == smf_pkg::SMF_IDLE) && (s_r.ctrl[smf_pkg::C_MDROP] ? s_r.pend
			: (s_r.ctrl[smf_pkg::C_RUN] && s_r.cnt == 32'h0));
		case (s_r.st)
			smf_pkg::SMF_IDLE: begin
				if (start) begin
					// Snapshot keeps the message coherent while software updates
					s_nxt.sctl = s_r.ctrl;
					s_nxt.sspd = s_r.spd;
					s_nxt.idx = 4'd0;
					s_nxt.kind = smf_pkg::K_LIVE;
					s_nxt.st = smf_pkg::SMF_HDR;
					s_nxt.pend = 1'b0;
					s_nxt.cnt = s_r.period;
				end
			end
			smf_pkg::SMF_HDR: begin
				if (adv) begin
					s_nxt.idx = s_r.idx + 4'd1;
					if (s_r.idx == hdr_len - 4'd1) begin
						s_nxt.idx = 4'd0;
						s_nxt.st = s_r.sctl[smf_pkg::C_FMT] ? smf_pkg::SMF_BLK : smf_pkg::SMF_CR;
					end
				end
			end
			smf_pkg::SMF_BLK: begin
				if (adv) begin
					s_nxt.idx = s_r.idx + 4'd1;
					if (s_r.idx == smf_pkg::LEN_BLOCK - 4'd1) begin
						s_nxt.idx = 4'd0;
						s_nxt.kind = next_kind(s_r.kind, s_r.sctl[smf_pkg::C_PEAK], s_r.sctl[smf_pkg::C_HIT]);
						s_nxt.st = last_blk ? smf_pkg::SMF_CR : smf_pkg::SMF_BLK;
					end
				end
			end
			smf_pkg::SMF_CR: begin
				if (adv) begin
					s_nxt.st = smf_pkg::SMF_DRAIN;
				end
			end
			smf_pkg::SMF_DRAIN: begin
				if (bif.empty && !tx_valid && tx_idle) begin
					s_nxt.st = smf_pkg::SMF_IDLE;
					s_nxt.msgs = s_r.msgs + 16'h1;
				end
			end
			default: s_nxt.st = smf_pkg::SMF_IDLE;
		endcase
		s_nxt.busy = (s_nxt.st != smf_pkg::SMF_IDLE);
		if (reg_wr) begin
			case (reg_addr)
				smf_pkg::OFS_CTRL: s_nxt.ctrl = reg_wdata[15:0];
				smf_pkg::OFS_PERIOD: s_nxt.period = reg_wdata;
				smf_pkg::OFS_POLL: s_nxt.pend = 1'b1;
				default: begin
					for (int i = 0; i < smf_pkg::NUM_SPD; i++) begin
						if (reg_addr == smf_pkg::OFS_SPD0 + 8'(4*i)) begin
							s_nxt.spd[i] = reg_wdata[19:0];
						end
					end
				end
			endcase
		end
		s_nxt.rdata = 32'h0;
		if (reg_rd) begin
			case (reg_addr)
				smf_pkg::OFS_CTRL: s_nxt.rdata = {16'h0, s_r.ctrl};
				smf_pkg::OFS_PERIOD: s_nxt.rdata = s_r.period;
				smf_pkg::OFS_STATUS: s_nxt.rdata = {s_r.msgs, 14'h0, s_r.pend, s_r.busy};
				default: begin
					for (int i = 0; i < smf_pkg::NUM_SPD; i++) begin
						if (reg_addr == smf_pkg::OFS_SPD0 + 8'(4*i)) begin
							s_nxt.rdata = {12'h0, s_r.spd[i]};
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.ctrl <= smf_pkg::CTRL_RST;
			s_r.period <= smf_pkg::PERIOD_RST;
			s_r.spd <= {smf_pkg::NUM_SPD{smf_pkg::SPD_RST}};
			s_r.sspd <= {smf_pkg::NUM_SPD{smf_pkg::SPD_RST}};
			s_r.st <= smf_pkg::SMF_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign busy = s_r.busy;

	property p_type_all;
		@(posedge core_clk) disable iff (!rst_b)
		s_r.st == smf_pkg::SMF_HDR && s_r.sctl[smf_pkg::C_FMT] && s_r.idx == 4'd0 |-> bif.data == 8'h88;
	endproperty
	a_type_all: assert property (p_type_all) else $error("all-speeds type byte wrong");

	property p_cfg_multi;
		@(posedge core_clk) disable iff (!rst_b)
		s_r.st == smf_pkg::SMF_HDR && !s_r.sctl[smf_pkg::C_FMT] && s_r.idx == 4'd1
		|-> bif.data[7:6] == 2'b01 && bif.data[2:1] == 2'b01 && bif.data[0] == s_r.sctl[smf_pkg::C_XMIT];
	endproperty
	a_cfg_multi: assert property (p_cfg_multi) else $error("multi config fixed bits wrong");

	property p_cfg_flags;
		@(posedge core_clk) disable iff (!rst_b)
		s_r.st == smf_pkg::SMF_HDR && !s_r.sctl[smf_pkg::C_FMT] && s_r.idx == 4'd1
		|-> bif.data[5:3] == {s_r.sctl[smf_pkg::C_LOCK], s_r.sctl[smf_pkg::C_OUTB], s_r.sctl[smf_pkg::C_FORK]};
	endproperty
	a_cfg_flags: assert property (p_cfg_flags) else $error("multi config flags wrong");

	property p_st_multi;
		@(posedge core_clk) disable iff (!rst_b)
		s_r.st == smf_pkg::SMF_HDR && !s_r.sctl[smf_pkg::C_FMT] && s_r.idx == 4'd2
		|-> bif.data == (8'h40 | (s_r.sctl[smf_pkg::C_PEAK] ? 8'h04 : 8'h00));
	endproperty
	a_st_multi: assert property (p_st_multi) else $error("multi status byte wrong");

	property p_cfg_all;
		@(posedge core_clk) disable iff (!rst_b)
		s_r.st == smf_pkg::SMF_HDR && s_r.sctl[smf_pkg::C_FMT] && s_r.idx inside {4'd1, 4'd2}
		|-> bif.data[7:6] == 2'b01 && (s_r.idx == 4'd2 ? bif.data[5:0] == 6'h04 : bif.data[5] == 1'b0);
	endproperty
	a_cfg_all: assert property (p_cfg_all) else $error("all-speeds config or status wrong");

	property p_block_id;
		@(posedge core_clk) disable iff (!rst_b)
		s_r.st == smf_pkg::SMF_BLK && s_r.idx == 4'd0
		|-> bif.data == (blk_alt ? 8'h37 : 8'h34) + {6'h00, s_r.kind};
	endproperty
	a_block_id: assert property (p_block_id) else $error("speed block id wrong");

	property p_hit_gated;
		@(posedge core_clk) disable iff (!rst_b)
		s_r.st == smf_pkg::SMF_BLK && s_r.kind == smf_pkg::K_HIT |-> s_r.sctl[smf_pkg::C_HIT];
	endproperty
	a_hit_gated: assert property (p_hit_gated) else $error("hit block without enable");

	property p_end_cr;
		@(posedge core_clk) disable iff (!rst_b)
		s_r.st == smf_pkg::SMF_BLK && s_r.idx == 4'd14 && adv && last_blk
		|=> s_r.st == smf_pkg::SMF_CR && bif.data == 8'h0d;
	endproperty
	a_end_cr: assert property (p_end_cr) else $error("carriage return missing after last block");

	property p_drained;
		@(posedge core_clk) disable iff (!rst_b)
		$rose(s_r.st == smf_pkg::SMF_HDR) |-> $past(tx_idle) && $past(bif.empty) && !tx_valid;
	endproperty
	a_drained: assert property (p_drained) else $error("message started before previous drained");

	property p_poll_only;
		@(posedge core_clk) disable iff (!rst_b)
		s_r.st == smf_pkg::SMF_IDLE && s_r.ctrl[smf_pkg::C_MDROP] && !s_r.pend |=> s_r.st == smf_pkg::SMF_IDLE;
	endproperty
	a_poll_only: assert property (p_poll_only) else $error("multidrop message without poll");
endmodule : smf_top

// >>> inc/smf_pkg.sv
// Purpose: Shared constants and types for the speed message formatter
// Assumes: Speeds arrive as five BCD nibbles, thousands down to tenths
// Notes: Nibble values above nine stand for a blank digit
package smf_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_POLL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_SPD0 = 8'h10;
	localparam int NUM_SPD = 5;
	// Speed slots
	localparam int SPD_LIVE = 0;
	localparam int SPD_LOCKED = 1;
	localparam int SPD_PEAK = 2;
	localparam int SPD_HIPEAK = 3;
	localparam int SPD_HIT = 4;
	// Control register fields
	localparam int C_FMT = 0;
	localparam int C_TENTHS = 1;
	localparam int C_PEAK = 2;
	localparam int C_HIT = 3;
	localparam int C_FORK = 4;
	localparam int C_LOCK = 5;
	localparam int C_OUTB = 6;
	localparam int C_XMIT = 7;
	localparam int C_MDROP = 8;
	localparam int C_RUN = 9;
	localparam int C_DIR = 10;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [31:0] PERIOD_RST = 32'h0001_e848;
	localparam logic [19:0] SPD_RST = 20'hfffff;
	// Message bytes
	localparam logic [7:0] B_TYPE_MULTI = 8'h81;
	localparam logic [7:0] B_TYPE_ALL = 8'h88;
	localparam logic [7:0] B_ZERO = 8'h30;
	localparam logic [7:0] B_SPACE = 8'h20;
	localparam logic [7:0] B_CR = 8'h0d;
	localparam logic [7:0] B_ID_STD = 8'h34;
	localparam logic [7:0] B_ID_ALT = 8'h37;
	localparam logic [7:0] B_CNT_ONE = 8'h31;
	localparam logic [1:0] B_ASCII_TOP = 2'b01;
	localparam logic [5:0] B_ALL_STATUS_LOW = 6'b000100;
	localparam logic [3:0] LEN_HDR_MULTI = 4'd15;
	localparam logic [3:0] LEN_HDR_ALL = 4'd7;
	localparam logic [3:0] LEN_BLOCK = 4'd15;
	// Block kinds
	localparam logic [1:0] K_LIVE = 2'd0;
	localparam logic [1:0] K_PEAK = 2'd1;
	localparam logic [1:0] K_HIT = 2'd2;
	localparam logic [1:0] K_NONE = 2'd3;

	typedef enum logic [4:0] {
		SMF_IDLE = 5'h01,
		SMF_HDR = 5'h02,
		SMF_BLK = 5'h04,
		SMF_CR = 5'h08,
		SMF_DRAIN = 5'h10
	} smf_st_t;

	function automatic logic [3:0] smf_nib(input logic [19:0] v, input logic [2:0] i);
		smf_nib = v[i*4 +: 4];
	endfunction : smf_nib

	function automatic logic [7:0] smf_asc(input logic [3:0] n);
		smf_asc = (n < 4'd10) ? (B_ZERO + {4'h0, n}) : B_SPACE;
	endfunction : smf_asc

	// A real thousands digit means the standard layout cannot hold it
	function automatic logic smf_big(input logic [19:0] v);
		smf_big = (v[19:16] != 4'h0) && (v[19:16] < 4'd10);
	endfunction : smf_big
endpackage : smf_pkg

// >>> inc/smf_byte_if.sv
// Purpose: Byte stream between the framer and its output buffer
// Assumes: One clock
// Notes: Empty lets the framer see that the buffer has drained
`timescale 1ns/100ps
interface smf_byte_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	logic empty;
	modport src (output data, output valid, input ready, input empty);
	modport snk (input data, input valid, output ready, output empty);
endinterface : smf_byte_if

// >>> rtl/smf_buf.sv
// Purpose: Two-entry byte buffer ahead of the serial transmitter
// Assumes: Same clock on both sides
// Notes: Output valid and data come straight from flops
`timescale 1ns/100ps
module smf_buf (
	input wire logic core_clk,
	input wire logic rst_b,
	smf_byte_if.snk in_if,
	output logic [7:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	typedef struct packed {
		logic [1:0][7:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
		logic vld;
		logic [7:0] dat;
	} smf_buf_t;

	smf_buf_t s_r;
	smf_buf_t s_nxt;
	logic push;
	logic pop;

	always_comb begin
		s_nxt = s_r;
		push = in_if.valid && (s_r.cnt != 2'd2);
		pop = s_r.vld && out_ready;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_if.data;
			s_nxt.wp = ~s_r.wp;
		end
		if (pop) begin
			s_nxt.rp = ~s_r.rp;
		end
		s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
		s_nxt.vld = (s_nxt.cnt != 2'd0);
		s_nxt.dat = s_nxt.mem[s_nxt.rp];
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign in_if.ready = (s_r.cnt != 2'd2);
	assign in_if.empty = (s_r.cnt == 2'd0);
	assign out_data = s_r.dat;
	assign out_valid = s_r.vld;
endmodule : smf_buf

// >>> rtl/smf_block.sv
// Purpose: Byte of one fifteen-byte speed block, standard or alternate
// Assumes: Index 0 to 14, kind live, peak or hit
// Notes: Purely combinational
`timescale 1ns/100ps
module smf_block (
	input wire logic [1:0] kind,
	input wire logic [3:0] idx,
	input wire logic [19:0] prim,
	input wire logic [19:0] sec,
	input wire logic [7:0] stat,
	output logic [7:0] byte_o,
	output logic alt
);
	logic hit;

	always_comb begin
		hit = (kind == smf_pkg::K_HIT);
		// Layout chosen per block from its own speeds
		alt = smf_pkg::smf_big(prim) || (!hit && smf_pkg::smf_big(sec));
		byte_o = smf_pkg::B_SPACE;
		if (idx == 4'd0) begin
			byte_o = (alt ? smf_pkg::B_ID_ALT : smf_pkg::B_ID_STD) + {6'h00, kind};
		end else if (idx == 4'd1) begin
			byte_o = stat;
		end else if (!alt) begin
			if (idx <= 4'd5) begin
				byte_o = smf_pkg::smf_asc(smf_pkg::smf_nib(prim, 3'(4'd5 - idx)));
			end else if (idx <= 4'd9) begin
				byte_o = hit ? smf_pkg::B_SPACE : smf_pkg::smf_asc(smf_pkg::smf_nib(sec, 3'(4'd9 - idx)));
			end
		end else begin
			if (idx <= 4'd6) begin
				byte_o = smf_pkg::smf_asc(smf_pkg::smf_nib(prim, 3'(4'd6 - idx)));
			end else if (idx <= 4'd11) begin
				byte_o = hit ? smf_pkg::B_SPACE : smf_pkg::smf_asc(smf_pkg::smf_nib(sec, 3'(4'd11 - idx)));
			end
		end
	end
endmodule : smf_block

// >>> bench/smf_uart_model.sv
// Purpose: Serial transmitter seen from the formatter, prompt or slow
// Assumes: Same clock as the formatter
// Notes: Slow mode stands for a low line rate and stalls the buffer
`timescale 1ns/100ps
module smf_uart_model (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic tx_idle,
	input wire logic slow
);
	logic [3:0] shift_r;
	// Byte time stands for the line rate the host picked
	assign tx_ready = (shift_r <= 4'h1);
	assign tx_idle = (shift_r == 4'h0);
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			shift_r <= 4'h0;
		end else if (tx_valid && tx_ready) begin
			shift_r <= slow ? 4'hb : 4'h1;
		end else if (shift_r != 4'h0) begin
			shift_r <= shift_r - 4'h1;
		end
	end
endmodule : smf_uart_model

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the speed message formatter
// Assumes: Messages started by poll in multidrop mode, or by period
// Notes: Expected frames are rebuilt here from the message layout
`timescale 1ns/100ps
module tb_top;
	typedef struct packed {
		logic [15:0] ctrl;
		logic [99:0] spd;
		logic slow;
		logic [7:0] len;
		logic [7:0] cfg;
	} smf_row_t;
	logic core_clk;
	logic rst_b;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_ready;
	logic tx_idle;
	logic busy;
	logic slow;
	int n_mismatch;
	int n_checks;
	logic [7:0] rxq[$];
	logic [7:0] exq[$];
	smf_row_t rows[5];

	smf_top DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_idle(tx_idle), .busy(busy));
	smf_uart_model u_uart (.core_clk(core_clk), .rst_b(rst_b), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_idle(tx_idle), .slow(slow));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (rst_b && tx_valid && tx_ready) begin
			rxq.push_back(tx_data);
		end
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp, what);
		@(posedge core_clk);
		#1;
		check(reg_rdata, 32'h0, "read data held too long");
	endtask : reg_read

	function automatic logic [7:0] dig(input logic [19:0] v, input int i);
		logic [3:0] n;
		n = v[i*4 +: 4];
		return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h20;
	endfunction : dig

	function automatic void add_blk(input int k, input logic [19:0] p, input logic [19:0] s, input logic [15:0] c);
		logic alt;
		int top;
		alt = (p[19:16] inside {[4'h1:4'h9]}) || (s[19:16] inside {[4'h1:4'h9]});
		top = alt ? 4 : 3;
		exq.push_back((alt ? 8'h37 : 8'h34) + 8'(k));
		exq.push_back({2'b01, 3'b000, c[11 + 2*k], c[10 + 2*k], c[7]});
		for (int i = top; i >= 0; i--)
			exq.push_back(dig(p, i));
		for (int i = top; i >= 0; i--)
			exq.push_back(k == 2 ? 8'h20 : dig(s, i));
		repeat (alt ? 3 : 5) exq.push_back(8'h20);
	endfunction : add_blk

	function automatic void build(input logic [15:0] c, input logic [99:0] s);
		logic [19:0] v[5];
		for (int i = 0; i < 5; i++)
			v[i] = s[i*20 +: 20];
		exq.delete();
		if (!c[0]) begin
			exq.push_back(8'h81);
			exq.push_back({2'b01, c[5], c[6], c[4], 1'b0, 1'b1, c[7]});
			exq.push_back({2'b01, 3'b000, c[2], 2'b00});
			repeat (3) exq.push_back(8'h30);
			// Locked, peak, live; tenths shifts the digit window down
			for (int j = 0; j < 3; j++)
				for (int i = 2; i >= 0; i--)
					exq.push_back(dig(v[j == 0 ? 1 : (j == 1 ? 2 : 0)], i + (c[1] ? 0 : 1)));
		end else begin
			exq.push_back(8'h88);
			exq.push_back({2'b01, 1'b0, c[1], 2'b00, c[2], c[4]});
			exq.push_back(8'h44);
			repeat (3) exq.push_back(8'h30);
			exq.push_back(8'h31 + 8'(c[2]) + 8'(c[3]));
			add_blk(0, v[0], v[1], c);
			if (c[2])
				add_blk(1, v[2], v[3], c);
			if (c[3])
				add_blk(2, v[4], 20'hfffff, c);
		end
		exq.push_back(8'h0d);
	endfunction : build

	// Needs several quiet cycles: busy dips between queued messages
	task automatic wait_idle;
		int t;
		int quiet;
		t = 0;
		quiet = 0;
		while (quiet < 8 && t < 5000) begin
			@(posedge core_clk);
			#1;
			quiet = (busy === 1'b0) ? quiet + 1 : 0;
			t++;
		end
		check({31'h0, t < 5000}, 32'h1, "message did not finish");
	endtask : wait_idle

	task automatic run_msg(input logic [15:0] c, input int npoll);
		reg_write(smf_pkg::OFS_CTRL, {16'h0, c | 16'h0100});
		rxq.delete();
		for (int p = 0; p < npoll; p++)
			reg_write(smf_pkg::OFS_POLL, 32'h1);
		wait_idle();
	endtask : run_msg

	task automatic cmp_msgs(input int reps, input string what);
		check(rxq.size(), exq.size() * reps, "byte count");
		foreach (rxq[i]) begin
			if (i < exq.size() * reps)
				check({24'h0, rxq[i]}, {24'h0, exq[i % exq.size()]}, what);
		end
	endtask : cmp_msgs

	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_mismatch = 0;
		n_checks = 0;
		rows[0] = '{16'h00f4, {20'hfffff, 20'hfffff, 20'h00987, 20'h01234, 20'h00550}, 1'b0, 8'd16, 8'h7b};
		rows[1] = '{16'h0002, {20'hfffff, 20'hfffff, 20'h00999, 20'hfffff, 20'h00585}, 1'b0, 8'd16, 8'h42};
		rows[2] = '{16'h0c81, {20'hfffff, 20'hfffff, 20'hfffff, 20'h00600, 20'h00123}, 1'b0, 8'd23, 8'h40};
		rows[3] = '{16'h541f, {20'h10000, 20'h12345, 20'h00999, 20'h00600, 20'h00585}, 1'b1, 8'd53, 8'h53};
		rows[4] = '{16'h8089, {20'h00420, 20'hfffff, 20'hfffff, 20'h00100, 20'h09999}, 1'b0, 8'd38, 8'h40};
		slow = rows[0].slow;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		// Polled starts reload the period too; a short one keeps streaming from stalling later
		reg_write(smf_pkg::OFS_PERIOD, 32'd50);
		foreach (rows[r]) begin
			slow <= rows[r].slow;
			for (int i = 0; i < 5; i++)
				reg_write(smf_pkg::OFS_SPD0 + 8'(4 * i), {12'h0, rows[r].spd[i*20 +: 20]});
			build(rows[r].ctrl, rows[r].spd);
			run_msg(rows[r].ctrl, 1);
			check(rxq.size(), rows[r].len, "message length");
			check(rxq.size() > 1 ? rxq[1] : 8'h0, rows[r].cfg, "config byte");
			cmp_msgs(1, "message byte");
		end
		// One completed message per row, nothing pending, not busy
		reg_read(smf_pkg::OFS_STATUS, 32'h0005_0000, "messages counted");
		// Second poll lands mid-message and must queue, not merge
		run_msg(rows[4].ctrl, 2);
		cmp_msgs(2, "queued poll byte");
		// Streaming by period; stopping mid-run must still finish the frame
		build(16'h0081, rows[4].spd);
		reg_write(smf_pkg::OFS_PERIOD, 32'd50);
		rxq.delete();
		reg_write(smf_pkg::OFS_CTRL, 32'h0000_0281);
		repeat (400) @(posedge core_clk);
		reg_write(smf_pkg::OFS_CTRL, 32'h0000_0081);
		wait_idle();
		check({31'h0, rxq.size() >= 2 * exq.size()}, 32'h1, "too few streamed messages");
		cmp_msgs(rxq.size() / exq.size(), "streamed byte");
		// Reset in the middle of a slow message
		slow <= rows[3].slow;
		reg_write(smf_pkg::OFS_CTRL, 32'h0000_0101);
		reg_write(smf_pkg::OFS_POLL, 32'h1);
		repeat (30) @(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check({31'h0, tx_valid}, 32'h0, "byte offered in reset");
		check({31'h0, busy}, 32'h0, "busy in reset");
		rst_b <= 1'b1;
		slow <= rows[0].slow;
		reg_read(smf_pkg::OFS_CTRL, 32'h0, "control reset value");
		reg_read(smf_pkg::OFS_PERIOD, 32'h0001_e848, "period reset value");
		reg_read(smf_pkg::OFS_SPD0, 32'h000f_ffff, "speed reset value");
		reg_write(smf_pkg::OFS_STATUS, 32'hffff_ffff);
		reg_read(smf_pkg::OFS_STATUS, 32'h0, "status after reset and write");
		reg_read(8'h40, 32'h0, "unmapped read");
		check({24'h0, tx_data}, 32'h0, "idle byte after reset");
		tally_and_finish();
	end
endmodule : tb_top
